// ===== hw/msps_motion.sv
// motion core: runs one linear step at a time, pulse per enable tick
// assumes steps arrive over msps_step_if and a hold flag level from the top
`timescale 1ns/100ps
module msps_motion
	import msps_pkg::*;
(
	input  wire logic           clk_sys,
	input  wire logic           resetn,
	msps_step_if.dst            step,
	input  wire logic           hold_flag,
	input  wire logic           mcode_off,
	input  wire logic [15:0]    accel_pulses,
	output logic                pulse_x,
	output logic                pulse_y,
	output logic                dir_x,
	output logic                dir_y,
	output logic                busy,
	output logic                mcode_on,
	output logic [6:0]          mcode_no
);
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT, ST_PAUSE} msps_mst_e;
	msps_mst_e          st;
	logic signed [31:0] pos_x;
	logic signed [31:0] pos_y;
	logic [31:0]        rem;
	logic [31:0]        elapsed;
	logic               mv_x;
	logic               mv_y;
	logic               cur_abs;
	logic               gate;
	logic               off_seen;
	logic               in_decel;
	logic               blend_ok;
	logic signed [31:0] next_tx;
	logic signed [31:0] next_ty;
	logic signed [31:0] dx;
	logic signed [31:0] dy;
	logic [17:0]        acc;
	logic               tick;
	logic [31:0]        adx;
	logic [31:0]        ady;
	logic [31:0]        travel;
	logic [17:0]        cur_spd;
	logic               take;

	////////////////////////////////////////////////////////////////
	assign in_decel = rem <= 32'(accel_pulses);
	// omitted axis keeps its position
	assign next_tx  = !step.has_x ? pos_x : (step.absolute ? step.x : pos_x + step.x); // (R15)
	assign next_ty  = !step.has_y ? pos_y : (step.absolute ? step.y : pos_y + step.y); // (R5)
	assign dx       = next_tx - pos_x;
	assign dy       = next_ty - pos_y;
	assign adx      = dx[31] ? -dx : dx;
	assign ady      = dy[31] ? -dy : dy;
	assign travel   = (adx > ady) ? adx : ady;
	// blend only if same drive method, long enough and next step can ramp
	assign blend_ok = (step.absolute == cur_abs) // (R1)
		&& (elapsed > 32'(SHORT_PATH_CYC)) // (R2)
		&& (travel >= 32'(accel_pulses)); // (R3)
	assign take     = step.valid && step.ready && !step.is_end;
	assign step.ready = (st == ST_IDLE) || (st == ST_PAUSE)
		|| (st == ST_RUN && rem == 32'h1 && tick && blend_ok && !gate);

	////////////////////////////////////////////////////////////////
	// phase accumulator: pulse rate is speed/2^18 of the clk_sys rate, no step count limit
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			acc  <= 18'h00000;
			tick <= 1'b0;
		end else begin
			// latched speed: later instruction inputs must not retune a running move
			{tick, acc} <= {1'b0, acc} + {1'b0, cur_spd};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			st       <= ST_IDLE;
			pos_x    <= 32'h00000000;
			pos_y    <= 32'h00000000;
			rem      <= 32'h00000000;
			elapsed  <= 32'h00000000;
			mv_x     <= 1'b0;
			mv_y     <= 1'b0;
			dir_x    <= 1'b0;
			dir_y    <= 1'b0;
			cur_abs  <= 1'b0;
			gate     <= 1'b0;
			off_seen <= 1'b0;
			mcode_on <= 1'b0;
			mcode_no <= MCODE_NONE;
			cur_spd  <= SPD_RESET;
			pulse_x  <= 1'b0;
			pulse_y  <= 1'b0;
		end else begin
			pulse_x <= 1'b0;
			pulse_y <= 1'b0;
			if (mcode_off) begin
				mcode_on <= 1'b0; // (R7)
			end
			if (mcode_off && st == ST_RUN && gate) begin
				off_seen <= 1'b1;
				if (!in_decel) begin
					gate <= 1'b0; // (R11)
				end
			end
			case (st)
				ST_IDLE, ST_PAUSE: begin
					// a queued step overrides this below
					st <= ST_IDLE;
				end
				ST_RUN: begin
					elapsed <= elapsed + 32'h1;
					if (tick && rem != 0) begin
						pulse_x <= mv_x;
						pulse_y <= mv_y;
						rem     <= rem - 32'h1;
						if (rem == 32'h1) begin
							if (gate && !off_seen) begin
								st <= ST_WAIT; // (R8) (R12)
							end else begin
								// a blending step is picked up below in this same cycle
								st <= ST_PAUSE; // (R6) (R10) (R13)
							end
						end
					end else if (rem == 0) begin
						st <= ST_PAUSE;
					end
				end
				ST_WAIT: begin
					if (mcode_off) begin
						gate <= 1'b0;
						st   <= ST_PAUSE; // (R9) (R12)
					end
				end
				default: st <= ST_IDLE;
			endcase
			if (take) begin
				st       <= ST_RUN;
				rem      <= travel;
				mv_x     <= dx != 0;
				mv_y     <= dy != 0;
				dir_x    <= !dx[31];
				dir_y    <= !dy[31];
				pos_x    <= next_tx;
				pos_y    <= next_ty;
				cur_abs  <= step.absolute;
				cur_spd  <= step.speed; // (R17)
				elapsed  <= 32'h00000000;
				// hold sampled once per transition
				gate     <= step.has_m && hold_flag; // (R20)
				off_seen <= 1'b0;
				if (step.has_m) begin
					mcode_on <= 1'b1; // (R7)
					mcode_no <= step.mcode;
				end
			end
		end
	end

	assign busy = st != ST_IDLE;
endmodule

// ===== hw/msps_pkg.sv
// package for the multistep path sequencer: codes, field layout, timing counts
// assumes a 125 MHz system clock
package msps_pkg;
	localparam int          CLK_MHZ        = 125;
	localparam int          SHORT_PATH_MS  = 50;
	localparam int          SHORT_PATH_CYC = SHORT_PATH_MS * 1000 * CLK_MHZ;
	localparam int          TICK_MS        = 10;
	localparam int          TICK_CYC       = TICK_MS * 1000 * CLK_MHZ;
	localparam int          POS_W          = 32;
	localparam int          SPD_W          = 18;
	localparam int          MCODE_W        = 7;
	localparam int          TIMK_W         = 16;
	localparam int          OP_W           = 7;
	localparam int          WORD_W         = 24;
	localparam logic [6:0]  OP_LIN         = 7'h01;
	localparam logic [6:0]  OP_CW          = 7'h02;
	localparam logic [6:0]  OP_CCW         = 7'h03;
	localparam logic [6:0]  OP_TIM         = 7'h04;
	localparam logic [6:0]  OP_ABS         = 7'h5a;
	localparam logic [6:0]  OP_INC         = 7'h5b;
	localparam logic [6:0]  OP_END         = 7'h7e;
	localparam logic [23:0] WORD_LIN       = 24'h4c494e;
	localparam logic [23:0] WORD_CW        = 24'h004357;
	localparam logic [23:0] WORD_CCW       = 24'h434357;
	localparam logic [23:0] WORD_TIM       = 24'h54494d;
	localparam logic [23:0] WORD_ABS       = 24'h414253;
	localparam logic [23:0] WORD_INC       = 24'h494e43;
	localparam logic [23:0] WORD_END       = 24'h454e44;
	localparam logic [17:0] SPD_RESET      = 18'h00000;
	localparam logic [6:0]  MCODE_NONE     = 7'h00;
endpackage

// ===== hw/msps_step_if.sv
// step descriptor carried from the decoder into the motion core
// assumes both ends run on clk_sys
`timescale 1ns/100ps
interface msps_step_if;
	logic                       valid;
	logic                       ready;
	logic                       absolute;
	logic                       has_x;
	logic                       has_y;
	logic signed [31:0]         x;
	logic signed [31:0]         y;
	logic [17:0]                speed;
	logic                       has_m;
	logic [6:0]                 mcode;
	logic                       is_end;
	modport src (output valid, absolute, has_x, has_y, x, y, speed, has_m, mcode, is_end,
		input ready);
	modport dst (input valid, absolute, has_x, has_y, x, y, speed, has_m, mcode, is_end,
		output ready);
endinterface

// ===== hw/msps_top.sv
// multistep path sequencer top: instruction decode, operand defaults, motion core
// assumes instructions come one per strobe from logic on clk_sys; pins are synchronised
`timescale 1ns/100ps
// Functional notes
// (R1) drive method change forces a stop
// (R2) paths of 50 ms or less stop
// (R3) too short to ramp means stop
// (R4) no limit on chained steps
// (R5) unspecified axis stays still
// (R6) without hold, m codes never halt chain
// (R7) m code on held until off
// (R8) with hold, wait for off command
// (R9) off command resumes next step
// (R10) off in decel finishes current target
// (R11) early off changes speed directly
// (R12) no off means stop and wait
// (R13) off in decel stops then continues
// (R14) instruction by word or code
// (R15) omitted coordinate keeps position
// (R16) omitted arc offset is zero
// (R17) omitted speed reuses last speed
// (R18) radius and timer mandatory, 10 ms ticks
// (R19) m code optional, never indirect
// (R20) hold flag sampled per transition
module msps_top
	import msps_pkg::*;
(
	input  wire logic               clk_sys,
	input  wire logic               resetn,
	input  wire logic               instr_valid,
	output logic                    instr_ready,
	input  wire logic               instr_by_word,
	input  wire logic [6:0]         instr_code,
	input  wire logic [23:0]        instr_word,
	input  wire logic               has_x,
	input  wire logic               has_y,
	input  wire logic signed [31:0] op_x,
	input  wire logic signed [31:0] op_y,
	input  wire logic               has_i,
	input  wire logic               has_j,
	input  wire logic signed [31:0] op_i,
	input  wire logic signed [31:0] op_j,
	input  wire logic               has_r,
	input  wire logic               has_f,
	input  wire logic [17:0]        op_f,
	input  wire logic               has_k,
	input  wire logic [15:0]        op_k,
	input  wire logic               has_m,
	input  wire logic               m_indirect,
	input  wire logic [6:0]         op_m,
	input  wire logic [15:0]        accel_pulses,
	input  wire logic               multistep_code_hold_flag,
	input  wire logic               mcode_off_pin,
	output logic                    instr_reject,
	output logic [6:0]              readback_code,
	output logic [23:0]             readback_word,
	output logic                    pulse_x,
	output logic                    pulse_y,
	output logic                    dir_x,
	output logic                    dir_y,
	output logic                    busy,
	output logic                    mcode_on,
	output logic [6:0]              mcode_no,
	output logic signed [31:0]      arc_i,
	output logic signed [31:0]      arc_j
);
	msps_step_if step ();
	logic [6:0]  op;
	logic        known;
	logic        absolute;
	logic [17:0] last_f;
	logic        hold_s1;
	logic        hold_s2;
	logic        off_s1;
	logic        off_s2;
	logic [31:0] tick_cnt;
	logic [15:0] tim_left;
	logic        timing;
	logic        bad;
	logic [23:0] op_word;

	////////////////////////////////////////////////////////////////
	// pins pass two flops
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			hold_s1 <= 1'b0;
			hold_s2 <= 1'b0;
			off_s1  <= 1'b0;
			off_s2  <= 1'b0;
		end else begin
			hold_s1 <= multistep_code_hold_flag;
			hold_s2 <= hold_s1;
			off_s1  <= mcode_off_pin;
			off_s2  <= off_s1;
		end
	end

	////////////////////////////////////////////////////////////////
	// word or code both name the same operation
	always_comb begin
		op    = instr_code;
		known = 1'b1;
		if (instr_by_word) begin // (R14)
			case (instr_word)
				WORD_LIN: op = OP_LIN;
				WORD_CW:  op = OP_CW;
				WORD_CCW: op = OP_CCW;
				WORD_TIM: op = OP_TIM;
				WORD_ABS: op = OP_ABS;
				WORD_INC: op = OP_INC;
				WORD_END: op = OP_END;
				default:  known = 1'b0;
			endcase
		end
	end

	// readback names the operation by word even when it came by code
	always_comb begin
		case (op)
			OP_LIN:  op_word = WORD_LIN;
			OP_CW:   op_word = WORD_CW;
			OP_CCW:  op_word = WORD_CCW;
			OP_TIM:  op_word = WORD_TIM;
			OP_ABS:  op_word = WORD_ABS;
			OP_INC:  op_word = WORD_INC;
			OP_END:  op_word = WORD_END;
			default: op_word = 24'h000000;
		endcase
	end

	// radius and timer constant may not be omitted; m code never indirect
	assign bad = !known
		|| ((op == OP_CW || op == OP_CCW) && !has_r) // (R18)
		|| (op == OP_TIM && !has_k) // (R18)
		|| (has_m && m_indirect); // (R19)

	assign step.valid    = instr_valid && !bad && !timing && (op == OP_LIN || op == OP_END);
	assign step.absolute = absolute;
	assign step.has_x    = has_x;
	assign step.has_y    = has_y;
	assign step.x        = op_x;
	assign step.y        = op_y;
	assign step.speed    = has_f ? op_f : last_f; // (R17)
	assign step.has_m    = has_m; // (R19)
	assign step.mcode    = op_m;
	assign step.is_end   = op == OP_END;

	// only motion steps wait on the core; the rest are taken at once when no dwell is running
	assign instr_ready = !timing && (bad || !(op == OP_LIN || op == OP_END) || step.ready);

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			absolute      <= 1'b0;
			last_f        <= SPD_RESET;
			instr_reject  <= 1'b0;
			readback_code <= 7'h00;
			readback_word <= 24'h000000;
			arc_i         <= 32'h00000000;
			arc_j         <= 32'h00000000;
		end else begin
			instr_reject <= instr_valid && bad && !timing;
			if (instr_valid && instr_ready && !bad) begin
				readback_code <= op; // (R14)
				readback_word <= op_word; // (R14)
				if (has_f) begin
					last_f <= op_f; // (R17)
				end
				if (op == OP_ABS) begin
					absolute <= 1'b1;
				end
				if (op == OP_INC) begin
					absolute <= 1'b0;
				end
				if (op == OP_CW || op == OP_CCW) begin
					arc_i <= has_i ? op_i : 32'h00000000; // (R16)
					arc_j <= has_j ? op_j : 32'h00000000; // (R16)
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// dwell counts whole 10 ms ticks
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			timing   <= 1'b0;
			tim_left <= 16'h0000;
			tick_cnt <= 32'h00000000;
		end else if (!timing) begin
			if (instr_valid && !bad && op == OP_TIM && op_k != 0) begin
				timing   <= 1'b1;
				tim_left <= op_k; // (R18)
				tick_cnt <= 32'h00000000;
			end
		end else if (tick_cnt == 32'(TICK_CYC - 1)) begin
			tick_cnt <= 32'h00000000;
			tim_left <= tim_left - 16'h1;
			timing   <= tim_left != 16'h1;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// unbounded chaining: each step is handed over as the last one ends
	msps_motion u_motion ( // (R4)
		.clk_sys      (clk_sys),
		.resetn       (resetn),
		.step         (step),
		.hold_flag    (hold_s2),
		.mcode_off    (off_s2),
		.accel_pulses (accel_pulses),
		.pulse_x      (pulse_x),
		.pulse_y      (pulse_y),
		.dir_x        (dir_x),
		.dir_y        (dir_y),
		.busy         (busy),
		.mcode_on     (mcode_on),
		.mcode_no     (mcode_no)
	);
endmodule

// ===== testbench/msps_chk.sv
// assertions on the sequencer top ports
// assumes a bind onto msps_top, single clk_sys domain
`timescale 1ns/100ps
module msps_chk
	import msps_pkg::*;
(
	input wire logic               clk_sys,
	input wire logic               resetn,
	input wire logic               instr_valid,
	input wire logic               instr_ready,
	input wire logic               instr_by_word,
	input wire logic [6:0]         instr_code,
	input wire logic               has_i,
	input wire logic               has_r,
	input wire logic               has_k,
	input wire logic               has_m,
	input wire logic               m_indirect,
	input wire logic               mcode_off_pin,
	input wire logic               instr_reject,
	input wire logic [6:0]         readback_code,
	input wire logic               pulse_x,
	input wire logic               pulse_y,
	input wire logic               busy,
	input wire logic               mcode_on,
	input wire logic signed [31:0] arc_i
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	//////////////////////////////////////////////////////////////////////////////
	sequence s_take;
		instr_valid && instr_ready;
	endsequence
	sequence s_code(logic [6:0] c);
		s_take ##0 !instr_by_word && instr_code == c;
	endsequence

	//////////////////////////////////////////////////////////////////////////////
	a_reject_has_cause: assert property (instr_reject |-> $past(instr_valid && instr_ready))
		else $error("reject without an offer");
	a_timer_needs_k: assert property (s_code(OP_TIM) ##0 !has_k |=> instr_reject)
		else $error("timer without k accepted");
	a_arc_needs_r: assert property (s_code(OP_CW) ##0 !has_r |=> instr_reject)
		else $error("arc without radius accepted");
	a_m_not_indirect: assert property (s_take ##0 has_m && m_indirect |=> instr_reject)
		else $error("indirect m code accepted");
	a_arc_zero_default: assert property (s_code(OP_CW) ##0 has_r && !has_i && !m_indirect
		|=> arc_i == 0)
		else $error("omitted arc offset not zero");
	a_code_readback: assert property (s_code(OP_ABS) ##0 !has_m |=> readback_code == OP_ABS)
		else $error("readback code wrong");
	a_mcode_release: assert property ($fell(mcode_on) |-> $past(mcode_off_pin, 1)
		|| $past(mcode_off_pin, 2) || $past(mcode_off_pin, 3) || $past(mcode_off_pin, 4))
		else $error("m code on dropped without off");
	a_pulse_in_motion: assert property ((pulse_x || pulse_y) |-> $past(busy))
		else $error("pulse while idle");
endmodule

bind msps_top msps_chk chk_u (.clk_sys(clk_sys), .resetn(resetn), .instr_valid(instr_valid),
	.instr_ready(instr_ready), .instr_by_word(instr_by_word), .instr_code(instr_code),
	.has_i(has_i), .has_r(has_r), .has_k(has_k), .has_m(has_m), .m_indirect(m_indirect),
	.mcode_off_pin(mcode_off_pin), .instr_reject(instr_reject), .readback_code(readback_code),
	.pulse_x(pulse_x), .pulse_y(pulse_y), .busy(busy), .mcode_on(mcode_on), .arc_i(arc_i));

// ===== testbench/msps_servo.sv
// drive model: counts step pulses into axis positions
// assumes registered one-cycle pulses with dir valid beside them
`timescale 1ns/100ps
module msps_servo (
	input  wire logic clk_sys,
	input  wire logic pulse_x,
	input  wire logic pulse_y,
	input  wire logic dir_x,
	input  wire logic dir_y,
	output int        pos_x,
	output int        pos_y
);
	initial begin
		pos_x = 0;
		pos_y = 0;
	end
	// each axis counted on its own, a stray y pulse shows at once
	always @(negedge clk_sys) begin
		if (pulse_x === 1'b1)
			pos_x <= pos_x + (dir_x ? 1 : -1);
		if (pulse_y === 1'b1)
			pos_y <= pos_y + (dir_y ? 1 : -1);
	end
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the multistep path sequencer
// assumes a 125 MHz clk_sys; the servo model stands on the pulse side
`timescale 1ns/100ps
module testbench
	import msps_pkg::*;
;
	logic clk_sys, resetn, instr_valid, instr_by_word, has_x, has_y, has_i, has_j, has_r;
	logic has_f, has_k, has_m, m_indirect, multistep_code_hold_flag, mcode_off_pin;
	logic instr_ready, instr_reject, pulse_x, pulse_y, dir_x, dir_y, busy, mcode_on;
	logic [6:0] instr_code, op_m, readback_code, mcode_no;
	logic [23:0] instr_word, readback_word;
	logic signed [31:0] op_x, op_y, op_i, op_j, arc_i, arc_j;
	logic [17:0] op_f;
	logic [15:0] op_k, accel_pulses;
	int pos_x, pos_y, fail_count, cmp_count, rejects, base;

	msps_top dut_u (.*);
	msps_servo servo_u (.clk_sys(clk_sys), .pulse_x(pulse_x), .pulse_y(pulse_y),
		.dir_x(dir_x), .dir_y(dir_y), .pos_x(pos_x), .pos_y(pos_y));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys)
		if (instr_reject === 1'b1)
			rejects++;

	//////////////////////////////////////////////////////////////////////////////
	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task timeout;
		fail_count++;
		$display("Error %0t: wait ran out", $time);
		test_done;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task issue(input logic [6:0] c, input logic [23:0] w, input int x, input logic hf,
		input logic hm, input logic [6:0] m);
		int n;
		n = 0;
		instr_code = c;
		instr_word = w;
		op_x = x;
		op_f = hf ? 18'h20000 : 18'h00000;
		has_f = hf;
		has_m = hm;
		op_m = m;
		instr_valid = 1'b1;
		@(negedge clk_sys);
		while (instr_ready !== 1'b1 && n < 3000) begin
			n++;
			@(negedge clk_sys);
		end
		if (n == 3000)
			timeout();
		step(1);
		instr_valid = 1'b0;
		{has_r, has_k, has_i, m_indirect, instr_by_word} = '0;
		step(1);
	endtask
	task wait_idle;
		int n;
		n = 0;
		step(2);
		while ((busy !== 1'b0 || instr_valid) && n < 3000) begin
			n++;
			step(1);
		end
		if (n == 3000)
			timeout();
	endtask

	//////////////////////////////////////////////////////////////////////////////
	task t_decode;
		for (int i = 0; i < 4; i++) begin
			instr_by_word = i[0];
			issue(i[0] ? 7'h00 : (i[1] ? OP_INC : OP_ABS),
				i[0] ? (i[1] ? WORD_INC : WORD_ABS) : 24'h000000, 0, 0, 0, 0);
			check(readback_code, i[1] ? OP_INC : OP_ABS);
			check(readback_word, i[1] ? WORD_INC : WORD_ABS);
		end
		$display("test decode done");
	endtask
	task t_chain;
		base = pos_x;
		issue(OP_LIN, WORD_LIN, 5, 1, 0, 0);
		issue(OP_LIN, WORD_LIN, 3, 0, 0, 0);
		issue(OP_LIN, WORD_LIN, 2, 0, 0, 0);
		wait_idle();
		check(pos_x, base + 10);
		check(pos_y, 0);
		issue(OP_ABS, WORD_ABS, 0, 0, 0, 0);
		issue(OP_LIN, WORD_LIN, 2, 1, 0, 0);
		wait_idle();
		check(pos_x, 2);
		check(dir_x, 0);
		issue(OP_INC, WORD_INC, 0, 0, 0, 0);
		$display("test chain done");
	endtask
	task t_reject;
		base = rejects;
		issue(OP_CW, WORD_CW, 0, 1, 0, 0);
		issue(OP_TIM, WORD_TIM, 0, 0, 0, 0);
		m_indirect = 1'b1;
		issue(OP_LIN, WORD_LIN, 1, 1, 1, 7'h05);
		instr_by_word = 1'b1;
		issue(7'h00, 24'h000000, 0, 0, 0, 0);
		step(2);
		check(rejects - base, 4);
		check(pos_x, 2);
		has_k = 1'b1;
		issue(OP_TIM, WORD_TIM, 0, 0, 0, 0);
		{has_r, has_i} = 2'b11;
		issue(OP_CW, WORD_CW, 0, 1, 0, 0);
		wait_idle();
		check(arc_i, 32'h00000007);
		has_r = 1'b1;
		issue(OP_CW, WORD_CW, 0, 1, 0, 0);
		wait_idle();
		check(arc_i, 32'h00000000);
		check(rejects - base, 4);
		$display("test reject done");
	endtask
	task t_hold;
		multistep_code_hold_flag = 1'b1;
		accel_pulses = 16'h0004;
		step(4);
		base = pos_x;
		issue(OP_LIN, WORD_LIN, 4, 1, 1, 7'h0a);
		fork
			issue(OP_LIN, WORD_LIN, 4, 1, 0, 0);
		join_none
		step(40);
		check(pos_x, base + 4);
		check(busy, 1);
		check(mcode_on, 1);
		check(mcode_no, 7'h0a);
		mcode_off_pin = 1'b1;
		wait_idle();
		check(pos_x, base + 8);
		check(mcode_on, 0);
		mcode_off_pin = 1'b0;
		multistep_code_hold_flag = 1'b0;
		step(4);
		$display("test hold done");
	endtask
	task t_off_early;
		for (int i = 0; i < 2; i++) begin
			multistep_code_hold_flag = 1'b1;
			// whole step inside the ramp region on the second pass
			accel_pulses = i[0] ? 16'h0010 : 16'h0002;
			step(4);
			base = pos_x;
			issue(OP_LIN, WORD_LIN, i[0] ? 12 : 40, 1, 1, 7'h0c);
			fork
				issue(OP_LIN, WORD_LIN, 4, 1, 0, 0);
			join_none
			step(4);
			mcode_off_pin = 1'b1;
			step(3);
			mcode_off_pin = 1'b0;
			wait_idle();
			check(pos_x, base + (i[0] ? 16 : 44));
			check(mcode_on, 0);
		end
		multistep_code_hold_flag = 1'b0;
		step(4);
		$display("test early off done");
	endtask
	task t_nohold;
		base = pos_x;
		issue(OP_LIN, WORD_LIN, 3, 1, 1, 7'h0b);
		issue(OP_LIN, WORD_LIN, 3, 1, 0, 0);
		wait_idle();
		check(pos_x, base + 6);
		check(mcode_on, 1);
		check(mcode_no, 7'h0b);
		mcode_off_pin = 1'b1;
		step(6);
		check(mcode_on, 0);
		mcode_off_pin = 1'b0;
		$display("test no hold done");
	endtask

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		{instr_valid, instr_by_word, has_y, has_i, has_j, has_r, has_f, has_k, has_m} = '0;
		{m_indirect, multistep_code_hold_flag, mcode_off_pin, resetn} = '0;
		has_x = 1'b1;
		{instr_code, op_m, instr_word, op_f, op_k} = '0;
		{op_x, op_y, op_j} = '0;
		op_i = 32'sh00000007;
		accel_pulses = 16'h0002;
		{fail_count, cmp_count, rejects} = '0;
		step(10);
		resetn = 1'b1;
		t_decode();
		t_chain();
		t_reject();
		t_hold();
		t_off_early();
		t_nohold();
		test_done();
	end
endmodule
